// ==== rtl/acq_sequencer.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - single command converts once, then steps channel
// - sample returned sign-extended to sixteen bits
// - code -128 is -5v, +127 is +4.961v
// - single sample reports its channel 0-7
// - default scan runs channel 0 to 7
// - missing end of conversion gives code 3
// - block writes samples to consecutive word addresses
// - block count above 32767 refused, code 11
// - block conversion starts on polled trigger rise
// - triggers ignored until start gate seen high
// - gate low later does not stop block
// - block done once last sample enters the fifo, before it is written out
// - abort stops block at once, code 5, except when the fifo accepts a push in that cycle
// - after upper limit reload lower limit
// - new limits restart scan at lower limit
module acq_sequencer (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// request from host
	input  wire logic        req_valid,
	input  wire logic [2:0]  function_selector,
	input  wire logic [15:0] req_arg0,
	input  wire logic [15:0] req_arg1,
	input  wire logic        abort_req,
	// completion to host
	output logic             done_valid,
	output logic [3:0]       done_result,
	output logic [15:0]      done_sample,
	output logic [2:0]       done_channel,
	output logic             busy,
	// block sample stream
	output logic             wr_valid,
	input  wire logic        wr_ready,
	output logic [15:0]      wr_addr,
	output logic [15:0]      wr_data,
	// converter and multiplexer
	output logic [2:0]       mux_sel,
	output logic             conv_start,
	input  wire logic        conv_done,
	input  wire logic [7:0]  conv_data,
	// external pins
	input  wire logic        trigger_in,
	input  wire logic        start_gate_input
);
	typedef enum {S_IDLE, S_WAIT_GATE, S_WAIT_TRIG, S_START, S_CONV, S_PUSH} state_t;

	state_t        st_reg, st_next;
	logic          init_reg, init_next, blk_reg, blk_next;
	logic [2:0]    lo_reg, lo_next, hi_reg, hi_next, ch_reg, ch_next;
	logic [15:0]   left_reg, left_next, addr_reg, addr_next, smp_reg, smp_next;
	logic [2:0]    sch_reg, sch_next;
	logic [$clog2(acq_pkg::EOC_TIMEOUT_CYC+1)-1:0] tmo_reg, tmo_next;
	logic          dv_reg, dv_next, cs_reg, cs_next;
	logic [3:0]    res_reg, res_next;
	logic [15:0]   dsmp_reg, dsmp_next;
	logic [2:0]    dch_reg, dch_next;
	logic [1:0]    trg_sync, gate_sync, done_sync;
	logic          trg_old;
	logic          f_ready, f_valid;
	logic [31:0]   f_data;
	logic [31:0]   f_in;
	logic          push;
	logic          trg_rise;
	logic          busy_reg, busy_next;

	// two-stage synchronisers; only stage one feeds stage two
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trg_sync  <= 2'h0;
			gate_sync <= 2'h0;
			done_sync <= 2'h0;
			trg_old   <= 1'b0;
		end else begin
			trg_sync  <= {trg_sync[0], trigger_in};
			gate_sync <= {gate_sync[0], start_gate_input};
			done_sync <= {done_sync[0], conv_done};
			trg_old   <= trg_sync[1];
		end
	end

	// polled edge, no interrupt path
	assign trg_rise = trg_sync[1] && !trg_old;

	// block samples pass a fifo so a slow sink stalls the sequencer
	assign f_in = {addr_reg, smp_reg};
	assign push = (st_reg == S_PUSH) && blk_reg;

	acq_fifo #(
		.WIDTH(acq_pkg::FIFO_WIDTH),
		.DEPTH(acq_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.reset_n  (reset_n),
		.in_valid (push),
		.in_ready (f_ready),
		.in_data  (f_in),
		.out_valid(f_valid),
		.out_ready(wr_ready),
		.out_data (f_data)
	);

	assign wr_valid = f_valid;
	assign wr_addr  = f_data[31:16];
	assign wr_data  = f_data[15:0];

	// sequencer next-state logic
	always_comb begin
		st_next   = st_reg;
		init_next = init_reg;
		blk_next  = blk_reg;
		lo_next   = lo_reg;
		hi_next   = hi_reg;
		ch_next   = ch_reg;
		left_next = left_reg;
		addr_next = addr_reg;
		smp_next  = smp_reg;
		sch_next  = sch_reg;
		tmo_next  = tmo_reg;
		dv_next   = 1'b0;
		cs_next   = 1'b0;
		res_next  = res_reg;
		dsmp_next = dsmp_reg;
		dch_next  = dch_reg;
		case (st_reg)
			S_IDLE: begin
				if (req_valid) begin
					dv_next = 1'b1;
					res_next = acq_pkg::RES_OK;
					if (function_selector == acq_pkg::FN_INIT) begin
						init_next = 1'b1;
						lo_next = acq_pkg::CHAN_FIRST;
						hi_next = acq_pkg::CHAN_LAST;
						ch_next = acq_pkg::CHAN_FIRST;
					end else if (function_selector > acq_pkg::FN_BLOCK) begin
						res_next = acq_pkg::RES_BADFUNC;
					end else if (!init_reg) begin
						res_next = acq_pkg::RES_NOINIT;
					end else if (function_selector == acq_pkg::FN_LIMITS) begin
						if (req_arg0 > 16'h0007)
							res_next = 4'hA;
						else if (req_arg1 > 16'h0007)
							res_next = acq_pkg::RES_BADCOUNT;
						else if (req_arg0 > req_arg1)
							res_next = acq_pkg::RES_BADLIM;
						else begin
							lo_next = req_arg0[2:0];
							hi_next = req_arg1[2:0];
							ch_next = req_arg0[2:0];
						end
					end else if (function_selector == acq_pkg::FN_SINGLE) begin
						dv_next = 1'b0;
						blk_next = 1'b0;
						st_next = S_START;
					end else if (req_arg1 > acq_pkg::COUNT_MAX) begin
						res_next = acq_pkg::RES_BADCOUNT;
					end else if (req_arg1 == 16'h0000) begin
						res_next = acq_pkg::RES_OK;
					end else begin
						dv_next = 1'b0;
						blk_next = 1'b1;
						left_next = req_arg1;
						addr_next = req_arg0;
						st_next = S_WAIT_GATE;
					end
				end
			end
			S_WAIT_GATE: begin
				// triggers before the gate are dropped
				if (gate_sync[1])
					st_next = S_WAIT_TRIG;
			end
			S_WAIT_TRIG: begin
				// gate no longer looked at here
				if (trg_rise)
					st_next = S_START;
			end
			S_START: begin
				cs_next = 1'b1;
				sch_next = ch_reg;
				tmo_next = '0;
				st_next = S_CONV;
			end
			S_CONV: begin
				tmo_next = tmo_reg + 1'b1;
				// done from the last conversion stays high until the start is seen,
				// so the synced level is only trusted once it has had time to drop
				if (done_sync[1] && tmo_reg >= ($bits(tmo_reg))'(acq_pkg::DONE_SETTLE_CYC)) begin
					// sign extension keeps 0 volts at code 0
					smp_next = {{8{conv_data[7]}}, conv_data};
					ch_next = (ch_reg == hi_reg) ? lo_reg : 3'(ch_reg + 1'b1);
					st_next = S_PUSH;
				end else if (tmo_reg == ($bits(tmo_reg))'(acq_pkg::EOC_TIMEOUT_CYC)) begin
					dv_next = 1'b1;
					res_next = acq_pkg::RES_HWFAIL;
					st_next = S_IDLE;
				end
			end
			S_PUSH: begin
				if (!blk_reg) begin
					dv_next = 1'b1;
					res_next = acq_pkg::RES_OK;
					dsmp_next = smp_reg;
					dch_next = sch_reg;
					st_next = S_IDLE;
				end else if (f_ready) begin
					addr_next = 16'(addr_reg + 16'h0002);
					left_next = 16'(left_reg - 1'b1);
					if (left_reg == 16'h0001) begin
						dv_next = 1'b1;
						res_next = acq_pkg::RES_OK;
						st_next = S_IDLE;
					end else
						st_next = S_WAIT_TRIG;
				end
			end
			default: st_next = S_IDLE;
		endcase
		// abort wins over any block step except a push the fifo accepts in that cycle
		if (blk_reg && abort_req && st_reg != S_IDLE && !(st_reg == S_PUSH && f_ready)) begin
			dv_next = 1'b1;
			res_next = acq_pkg::RES_ABORT;
			cs_next = 1'b0;
			st_next = S_IDLE;
		end
		busy_next = (st_next != S_IDLE);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg   <= S_IDLE;
			init_reg <= 1'b0;
			blk_reg  <= 1'b0;
			lo_reg   <= 3'h0;
			hi_reg   <= 3'h7;
			ch_reg   <= 3'h0;
			left_reg <= 16'h0000;
			addr_reg <= 16'h0000;
			smp_reg  <= 16'h0000;
			sch_reg  <= 3'h0;
			tmo_reg  <= '0;
			dv_reg   <= 1'b0;
			cs_reg   <= 1'b0;
			res_reg  <= 4'h0;
			dsmp_reg <= 16'h0000;
			dch_reg  <= 3'h0;
			busy_reg <= 1'b0;
		end else begin
			st_reg   <= st_next;
			init_reg <= init_next;
			blk_reg  <= blk_next;
			lo_reg   <= lo_next;
			hi_reg   <= hi_next;
			ch_reg   <= ch_next;
			left_reg <= left_next;
			addr_reg <= addr_next;
			smp_reg  <= smp_next;
			sch_reg  <= sch_next;
			tmo_reg  <= tmo_next;
			dv_reg   <= dv_next;
			cs_reg   <= cs_next;
			res_reg  <= res_next;
			dsmp_reg <= dsmp_next;
			dch_reg  <= dch_next;
			busy_reg <= busy_next;
		end
	end

	// outputs straight from flops
	assign done_valid   = dv_reg;
	assign done_result  = res_reg;
	assign done_sample  = dsmp_reg;
	assign done_channel = dch_reg;
	assign busy         = busy_reg;
	assign mux_sel      = ch_reg;
	assign conv_start   = cs_reg;
endmodule

// ==== include/acq_pkg.sv ====
package acq_pkg;
	// result codes returned with each request
	localparam logic [3:0] RES_OK       = 4'h0;
	localparam logic [3:0] RES_NOINIT   = 4'h1;
	localparam logic [3:0] RES_BADFUNC  = 4'h2;
	localparam logic [3:0] RES_HWFAIL   = 4'h3;
	localparam logic [3:0] RES_BADLIM   = 4'h4;
	localparam logic [3:0] RES_ABORT    = 4'h5;
	localparam logic [3:0] RES_BADCOUNT = 4'hB;

	// function selector codes
	localparam logic [2:0] FN_INIT   = 3'h0;
	localparam logic [2:0] FN_LIMITS = 3'h1;
	localparam logic [2:0] FN_SINGLE = 3'h2;
	localparam logic [2:0] FN_BLOCK  = 3'h3;

	// channel range and defaults after initialization
	localparam logic [2:0] CHAN_FIRST = 3'h0;
	localparam logic [2:0] CHAN_LAST  = 3'h7;

	// largest legal block count
	localparam logic [15:0] COUNT_MAX = 16'h7FFF;

	// clock and timeout for end of conversion
	localparam int CLK_HZ          = 20000000;
	localparam int EOC_TIMEOUT_US  = 100;
	localparam int EOC_TIMEOUT_CYC = EOC_TIMEOUT_US * (CLK_HZ / 1000000);
	// cycles a stale done level needs to clear through the synchroniser
	localparam int DONE_SETTLE_CYC = 3;

	// fifo shape
	localparam int FIFO_WIDTH = 32;
	localparam int FIFO_DEPTH = 8;
endpackage

// ==== rtl/acq_fifo.sv ====
`timescale 1ns/10ps
module acq_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             push, pop;

	// honest flags from the occupancy count
	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer and count update
	always_comb begin
		wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
		rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
		cnt_next = cnt_reg;
		if (push && !pop)
			cnt_next = (AW+1)'(cnt_reg + 1'b1);
		else if (pop && !push)
			cnt_next = (AW+1)'(cnt_reg - 1'b1);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// storage is not reset; only written words are ever read
	always_ff @(posedge clk) begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end
endmodule

// ==== sim/acq_properties.sv ====
`timescale 1ns/10ps
module acq_properties (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// host side
	input  wire logic        busy,
	input  wire logic        done_valid,
	input  wire logic [3:0]  done_result,
	input  wire logic [15:0] done_sample,
	// sample stream
	input  wire logic        wr_valid,
	input  wire logic        wr_ready,
	input  wire logic [15:0] wr_addr,
	input  wire logic [15:0] wr_data,
	// converter side
	input  wire logic [2:0]  mux_sel,
	input  wire logic        conv_start,
	input  wire logic        conv_done
);
	logic        pend_reg;
	logic        pend_next;
	logic [11:0] wait_reg;
	logic [11:0] wait_next;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// cycles spent waiting on one conversion
	always_comb begin
		// a start arms the count even while the old done level still stands
		pend_next = conv_start | (pend_reg & ~conv_done & ~done_valid);
		wait_next = pend_reg ? wait_reg + 12'h001 : 12'h000;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_reg <= 1'b0;
			wait_reg <= 12'h000;
		end else begin
			pend_reg <= pend_next;
			wait_reg <= wait_next;
		end
	end
	a_start_pulse: assert property (conv_start |=> !conv_start) else $error("start too long");
	a_start_busy: assert property (conv_start |-> busy) else $error("start while idle");
	a_mux_held: assert property (conv_start |=> $stable(mux_sel) [*2]) else $error("mux moved");
	a_done_pulse: assert property (done_valid |=> !done_valid) else $error("done too long");
	a_sample_sign: assert property (done_valid |-> done_sample[15:8] == {8{done_sample[7]}})
		else $error("sample not extended");
	a_word_sign: assert property (wr_valid |-> wr_data[15:8] == {8{wr_data[7]}})
		else $error("word not extended");
	a_word_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data)
		&& $stable(wr_addr)) else $error("word dropped");
	a_eoc_bound: assert property (wait_reg <= 12'h7DA) else $error("no timeout");
	a_hwfail_late: assert property (done_valid && done_result == acq_pkg::RES_HWFAIL
		|-> wait_reg >= 12'h7C6) else $error("early timeout");
	// main scenarios
	cover property (done_valid && done_result == acq_pkg::RES_ABORT);
	cover property (done_valid && done_result == acq_pkg::RES_HWFAIL);
	cover property (wr_valid && !wr_ready);
endmodule
bind acq_sequencer acq_properties chk (.clk(clk), .reset_n(reset_n), .busy(busy),
	.done_valid(done_valid), .done_result(done_result), .done_sample(done_sample),
	.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
	.mux_sel(mux_sel), .conv_start(conv_start), .conv_done(conv_done));

// ==== sim/conv_model.sv ====
`timescale 1ns/10ps
module conv_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// converter control
	input  wire logic       conv_start,
	input  wire logic [2:0] mux_sel,
	input  wire logic       mute,
	// converter result
	output logic            conv_done,
	output logic [7:0]      conv_data
);
	logic [2:0] ch_reg;
	logic [3:0] cnt_reg;
	// data toggles until done, so a stale read never matches
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= 4'h0;
			ch_reg <= 3'h0;
			conv_done <= 1'b0;
			conv_data <= 8'h55;
		end else begin
			if (!conv_done) conv_data <= ~conv_data;
			if (conv_start) begin
				cnt_reg <= 4'h5;
				conv_done <= 1'b0;
				ch_reg <= mux_sel;
			end else if (cnt_reg != 4'h0) begin
				cnt_reg <= cnt_reg - 4'h1;
				if (cnt_reg == 4'h1 && !mute) begin
					conv_done <= 1'b1;
					conv_data <= {ch_reg, 5'h00} ^ 8'h80;
				end
			end
		end
	end
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/10ps
module tb;
	typedef struct packed {logic [2:0] f; logic [15:0] x; logic [15:0] y; logic [3:0] r;} row_t;
	logic clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, abort_req = 1'b0, wr_ready = 1'b1;
	logic trigger_in = 1'b0, start_gate_input = 1'b0, mute = 1'b0, got_done = 1'b0;
	logic [2:0] fn = 3'h0;
	logic [15:0] a0 = 16'h0000, a1 = 16'h0000;
	logic done_valid, busy, wr_valid, conv_start, conv_done;
	logic [3:0] done_result;
	logic [15:0] done_sample, wr_addr, wr_data;
	logic [2:0] done_channel, mux_sel;
	logic [7:0] conv_data;
	logic [15:0] wq_addr[$], wq_data[$];
	int tests_run = 0, n_mismatch = 0;
	row_t rows[9] = '{'{acq_pkg::FN_SINGLE, 16'h0000, 16'h0000, acq_pkg::RES_NOINIT},
		'{acq_pkg::FN_INIT, 16'h0000, 16'h0000, acq_pkg::RES_OK},
		'{3'h5, 16'h0000, 16'h0000, acq_pkg::RES_BADFUNC},
		'{acq_pkg::FN_LIMITS, 16'h0008, 16'h0007, 4'hA},
		'{acq_pkg::FN_LIMITS, 16'h0000, 16'h0009, 4'hB},
		'{acq_pkg::FN_LIMITS, 16'h0005, 16'h0003, acq_pkg::RES_BADLIM},
		'{acq_pkg::FN_BLOCK, 16'h0000, 16'h8000, acq_pkg::RES_BADCOUNT},
		'{acq_pkg::FN_BLOCK, 16'h0000, 16'h0000, acq_pkg::RES_OK},
		'{acq_pkg::FN_LIMITS, 16'h0000, 16'h0007, acq_pkg::RES_OK}};
	always #25 clk = ~clk;
	acq_sequencer uut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
		.function_selector(fn), .req_arg0(a0), .req_arg1(a1), .abort_req(abort_req),
		.done_valid(done_valid), .done_result(done_result), .done_sample(done_sample),
		.done_channel(done_channel), .busy(busy), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_addr(wr_addr), .wr_data(wr_data), .mux_sel(mux_sel), .conv_start(conv_start),
		.conv_done(conv_done), .conv_data(conv_data), .trigger_in(trigger_in),
		.start_gate_input(start_gate_input));
	conv_model model (.clk(clk), .reset_n(reset_n), .conv_start(conv_start),
		.mux_sel(mux_sel), .mute(mute), .conv_done(conv_done), .conv_data(conv_data));
	// answer latch and unbounded word sink
	always @(posedge clk) begin
		if (done_valid === 1'b1) got_done <= 1'b1;
		if (wr_valid === 1'b1 && wr_ready) begin
			wq_addr.push_back(wr_addr);
			wq_data.push_back(wr_data);
		end
	end
	function automatic logic [15:0] smp(input logic [2:0] c);
		logic [7:0] d;
		d = {c, 5'h00} ^ 8'h80;
		return {{8{d[7]}}, d};
	endfunction
	task test_done;
		if (n_mismatch == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk_res(input string n, input logic [3:0] e, input logic [3:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task chk_w(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task send(input logic [2:0] f, input logic [15:0] x, input logic [15:0] y);
		@(posedge clk);
		got_done = 1'b0;
		fn <= f;
		a0 <= x;
		a1 <= y;
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
	endtask
	task wait_done(input int lim);
		for (int i = 0; i < lim && got_done !== 1'b1; i++) @(posedge clk);
		if (got_done !== 1'b1) begin
			n_mismatch++;
			test_done;
		end
	endtask
	task req(input logic [2:0] f, input logic [15:0] x, input logic [15:0] y, input logic [3:0] r);
		send(f, x, y);
		wait_done(50);
		chk_res("result", r, done_result);
	endtask
	task single(input logic [2:0] ch);
		send(acq_pkg::FN_SINGLE, 16'h0000, 16'h0000);
		wait_done(50);
		chk_res("result", acq_pkg::RES_OK, done_result);
		chk_w("channel", {13'h0000, ch}, {13'h0000, done_channel});
		chk_w("sample", smp(ch), done_sample);
	endtask
	// slow enough for the source rate limit
	task trig(input int n);
		repeat (n) begin
			trigger_in <= 1'b1;
			repeat (3350) @(posedge clk);
			trigger_in <= 1'b0;
			repeat (3350) @(posedge clk);
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		foreach (rows[i]) req(rows[i].f, rows[i].x, rows[i].y, rows[i].r);
		for (int i = 0; i < 9; i++) single(3'(i));
		req(acq_pkg::FN_LIMITS, 16'h0003, 16'h0004, acq_pkg::RES_OK);
		for (int i = 0; i < 3; i++) single(3'(3 + i % 2));
		mute <= 1'b1;
		send(acq_pkg::FN_SINGLE, 16'h0000, 16'h0000);
		wait_done(2200);
		chk_res("timeout", acq_pkg::RES_HWFAIL, done_result);
		mute <= 1'b0;
		// block with the stream stalled so the fifo fills
		req(acq_pkg::FN_LIMITS, 16'h0003, 16'h0004, acq_pkg::RES_OK);
		wr_ready <= 1'b0;
		send(acq_pkg::FN_BLOCK, 16'h0100, 16'h0008);
		trig(1);
		chk_res("gated", 4'h0, {3'h0, wr_valid});
		start_gate_input <= 1'b1;
		repeat (20) @(posedge clk);
		start_gate_input <= 1'b0;
		trig(7);
		chk_res("early", 4'h0, {3'h0, got_done});
		trig(1);
		wait_done(100);
		chk_res("result", acq_pkg::RES_OK, done_result);
		wr_ready <= 1'b1;
		repeat (30) @(posedge clk);
		chk_w("count", 16'h0008, 16'(wq_addr.size()));
		for (int i = 0; i < 8; i++) begin
			chk_w("addr", 16'h0100 + 16'(2 * i), wq_addr[i]);
			chk_w("data", smp(3'(3 + i % 2)), wq_data[i]);
		end
		// abort after one word
		start_gate_input <= 1'b1;
		send(acq_pkg::FN_BLOCK, 16'h0200, 16'h0005);
		trig(1);
		abort_req <= 1'b1;
		wait_done(10);
		abort_req <= 1'b0;
		chk_res("abort", acq_pkg::RES_ABORT, done_result);
		trig(1);
		chk_w("count", 16'h0009, 16'(wq_addr.size()));
		test_done;
	end
endmodule
